// ==== design/uart_line_control.sv ====
// Line format register, divisor access, break and loopback steering,
// wrapped round a small transmitter and receiver.
// Assumes a one-cycle strobe register port on ref_clk.
//
// How it works
// - The divisor access bit changes only while the unit is idle.
// - With divisor access set the shared offsets reach the divisor.
// - Break without loopback holds the serial output low.
// - Break with infrared on keeps pulsing the infrared output.
// - Break in loopback goes to the receiver; infrared output low.
// - Even select gives an even count of ones, else odd.
// - Format fields other than break change only while the unit is idle.
// - Parity enable turns parity on for both directions.
// - Stop field one gives 1.5 stop bits at five bits, else two.
// - The receiver checks only the first stop bit.
// - Data length codes 00 to 11 give five to eight bits.
// - Plain loopback holds the output high and feeds tx to rx.
`timescale 1ns/1ps
`include "uart_line_map.svh"
module uart_line_control
  import uart_line_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic serial_in,
  input wire logic ir_in,
  output logic serial_out,
  output logic ir_out
);
  logic [7:0] line_format;
  logic [7:0] modem_control;
  logic [15:0] divisor;
  logic [7:0] rx_char;
  logic rx_valid;
  logic rx_parity_error;
  logic rx_frame_error;
  logic serial_meta;
  logic serial_sync;
  logic ir_meta;
  logic ir_sync;
  logic break_pulse;
  logic tx_line;
  logic tx_first_half;
  logic tx_tick;
  logic tx_busy;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_par_err;
  logic rx_frm_err;
  logic rx_busy;

  wire busy = tx_busy || rx_busy;
  wire divisor_latch_access = line_format[`LF_DIVISOR_LATCH_ACCESS];
  wire break_control = line_format[`LF_BREAK_CONTROL];
  wire even_parity_select = line_format[`LF_EVEN_PARITY_SELECT];
  wire parity_enable = line_format[`LF_PARITY_ENABLE];
  wire stop_bits = line_format[`LF_STOP_BITS];
  wire [1:0] data_length_select =
    line_format[`LF_DATA_LENGTH_HI:`LF_DATA_LENGTH_LO];
  wire loopback = modem_control[`MC_LOOPBACK];
  wire infrared = modem_control[`MC_INFRARED];

  // Address decode. Software must leave divisor access clear for
  // normal data traffic; data writes go to the divisor low byte while it is set.
  wire hit_low = (addr == `ADDR_DATA_OR_DIV_LOW);
  wire hit_high = (addr == `ADDR_DIV_HIGH_SHARED);
  wire hit_format = (addr == `ADDR_LINE_FORMAT);
  wire hit_modem = (addr == `ADDR_MODEM_CONTROL);
  wire hit_status = (addr == `ADDR_UNIT_STATUS);
  wire wr_div_low = wr && hit_low && divisor_latch_access;
  wire wr_div_high = wr && hit_high && divisor_latch_access;
  wire wr_tx = wr && hit_low && !divisor_latch_access && !tx_busy;
  wire rd_rx = rd && hit_low && !divisor_latch_access;
  wire wr_format = wr && hit_format;
  wire wr_modem = wr && hit_modem;

  // All format bits but break are locked while busy; break stays writable so
  // a break can be raised mid-character.
  wire [7:0] format_lock_mask = busy ?
    (8'h01 << `LF_BREAK_CONTROL) : `LF_WRITABLE_MASK;
  wire [7:0] next_line_format =
    (line_format & ~format_lock_mask) |
    (wdata[7:0] & format_lock_mask);

  wire [31:0] status_word = {28'h0, rx_frame_error, rx_parity_error,
    rx_valid, busy};
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0;
    if (hit_low && divisor_latch_access)
      next_rdata = {24'h0, divisor[7:0]};
    else if (hit_low)
      next_rdata = {24'h0, rx_char};
    else if (hit_high && divisor_latch_access)
      next_rdata = {24'h0, divisor[15:8]};
    else if (hit_format)
      next_rdata = {24'h0, line_format};
    else if (hit_modem)
      next_rdata = {24'h0, modem_control};
    else if (hit_status)
      next_rdata = status_word;
  end

  // Loopback path carries the break into the receiver.
  wire loop_line = break_control ? 1'b0 : tx_line;
  wire rx_line = loopback ? loop_line :
    infrared ? !ir_sync : serial_sync;

  wire next_serial_out = loopback ? 1'b1 :
    break_control ? 1'b0 : tx_line;
  wire next_ir_out = (loopback || !infrared) ? 1'b0 :
    break_control ? break_pulse :
    (tx_busy && !tx_line && tx_first_half);

  char_transmit u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(wr_tx),
    .data(wdata[7:0]),
    .data_length_select(data_length_select),
    .stop_bits(stop_bits),
    .parity_enable(parity_enable),
    .even_parity_select(even_parity_select),
    .divisor(divisor),
    .tx_line(tx_line),
    .first_half(tx_first_half),
    .half_tick(tx_tick),
    .busy(tx_busy)
  );

  char_receive u_rx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rx_line(rx_line),
    .data_length_select(data_length_select),
    .parity_enable(parity_enable),
    .even_parity_select(even_parity_select),
    .divisor(divisor),
    .done(rx_done),
    .data(rx_data),
    .parity_error(rx_par_err),
    .frame_error(rx_frm_err),
    .busy(rx_busy)
  );

  always_ff @(posedge ref_clk)
  begin
    serial_meta <= serial_in;
    serial_sync <= serial_meta;
    ir_meta <= ir_in;
    ir_sync <= ir_meta;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      line_format <= `LF_RESET;
      modem_control <= `MC_RESET;
      divisor <= `DIVISOR_RESET;
    end
    else
    begin
      if (wr_format)
        line_format <= next_line_format;
      if (wr_modem)
        modem_control <= wdata[7:0];
      if (wr_div_low)
        divisor[7:0] <= wdata[7:0];
      if (wr_div_high)
        divisor[15:8] <= wdata[7:0];
    end
  end

  // A character that lands in the cycle of a read still sets valid.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_char <= 8'h0;
      rx_valid <= 1'b0;
      rx_parity_error <= 1'b0;
      rx_frame_error <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_char <= rx_data;
      rx_valid <= 1'b1;
      rx_parity_error <= rx_par_err;
      rx_frame_error <= rx_frm_err;
    end
    else if (rd_rx)
    begin
      rx_valid <= 1'b0;
      rx_parity_error <= 1'b0;
      rx_frame_error <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h0;
      serial_out <= 1'b1;
      ir_out <= 1'b0;
      break_pulse <= 1'b0;
    end
    else
    begin
      rdata <= rd ? next_rdata : 32'h0;
      serial_out <= next_serial_out;
      ir_out <= next_ir_out;
      if (tx_tick)
        break_pulse <= !break_pulse;
    end
  end
endmodule

// ==== shared/uart_line_map.svh ====
// Register offsets, field positions, reset values and timing for the
// line control logic. Included by the package user files by bare name.
`ifndef UART_LINE_MAP_SVH
`define UART_LINE_MAP_SVH

`define ADDR_DATA_OR_DIV_LOW 32'h5000_1100
`define ADDR_DIV_HIGH_SHARED 32'h5000_1104
`define ADDR_LINE_FORMAT 32'h5000_110c
`define ADDR_MODEM_CONTROL 32'h5000_1110
`define ADDR_UNIT_STATUS 32'h5000_111c

`define LF_DIVISOR_LATCH_ACCESS 7
`define LF_BREAK_CONTROL 6
`define LF_EVEN_PARITY_SELECT 4
`define LF_PARITY_ENABLE 3
`define LF_STOP_BITS 2
`define LF_DATA_LENGTH_HI 1
`define LF_DATA_LENGTH_LO 0
`define LF_WRITABLE_MASK 8'hdf
`define LF_RESET 8'h00

`define MC_LOOPBACK 4
`define MC_INFRARED 6
`define MC_RESET 8'h00

`define US_BUSY 0
`define US_RX_VALID 1
`define US_PARITY_ERROR 2
`define US_FRAME_ERROR 3

`define DIVISOR_RESET 16'h0001
`define MIN_DATA_BITS 4'h5

`endif

// ==== shared/uart_line_pkg.sv ====
// Types shared by the serial line control design files.
package uart_line_pkg;
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_START,
    SER_DATA,
    SER_PARITY,
    SER_STOP
  } ser_state_e;
endpackage

// ==== design/char_transmit.sv ====
// Serialises one character at the programmed format.
// Assumes the divisor gives clocks per half bit and start is one cycle.
`timescale 1ns/1ps
`include "uart_line_map.svh"
module char_transmit
  import uart_line_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic [1:0] data_length_select,
  input wire logic stop_bits,
  input wire logic parity_enable,
  input wire logic even_parity_select,
  input wire logic [15:0] divisor,
  output logic tx_line,
  output logic first_half,
  output logic half_tick,
  output logic busy
);
  ser_state_e state;
  logic [15:0] tcnt;
  logic [2:0] ht;
  logic [2:0] bidx;
  logic [7:0] shreg;
  logic par;
  wire [15:0] lim = (divisor == 16'h0) ? 16'h0 : divisor - 16'h1;
  // A divisor cut below the running count must still end the half bit,
  // or the counter would run all the way round first.
  wire tick = (tcnt >= lim);
  wire [2:0] last_bit = {1'b0, data_length_select} + 3'h4;
  // Bits above the programmed length must not reach the parity.
  wire [2:0] drop_bits = 3'h3 - {1'b0, data_length_select};
  wire [7:0] used_data = data & (8'hff >> drop_bits);
  // Half bits of stop: two, three for 1.5 with five bits, or four.
  wire [2:0] stop_last = !stop_bits ? 3'h1 :
    (data_length_select == 2'b00) ? 3'h2 : 3'h3;
  wire [2:0] elem_last = (state == SER_STOP) ? stop_last : 3'h1;
  wire elem_end = tick && (ht == elem_last);
  assign busy = (state != SER_IDLE);
  assign first_half = (ht == 3'h0);
  assign half_tick = tick;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= SER_IDLE;
      tcnt <= 16'h0;
      ht <= 3'h0;
      bidx <= 3'h0;
      shreg <= 8'h0;
      par <= 1'b0;
      tx_line <= 1'b1;
    end
    else
    begin
      tcnt <= (tick || (start && !busy)) ? 16'h0 : tcnt + 16'h1;
      if (tick)
        ht <= elem_end ? 3'h0 : ht + 3'h1;
      case (state)
        SER_IDLE:
          if (start)
          begin
            state <= SER_START;
            shreg <= data;
            // Even select makes parity equal the XOR of the data.
            par <= even_parity_select ? ^used_data : ~^used_data;
            bidx <= 3'h0;
            ht <= 3'h0;
            tx_line <= 1'b0;
          end
        SER_START:
          if (elem_end)
          begin
            state <= SER_DATA;
            tx_line <= shreg[0];
          end
        SER_DATA:
          if (elem_end)
          begin
            if (bidx == last_bit)
            begin
              // Parity sits between the last data bit and the stop.
              state <= parity_enable ? SER_PARITY : SER_STOP;
              tx_line <= parity_enable ? par : 1'b1;
            end
            else
            begin
              bidx <= bidx + 3'h1;
              tx_line <= shreg[bidx + 3'h1];
            end
          end
        SER_PARITY:
          if (elem_end)
          begin
            state <= SER_STOP;
            tx_line <= 1'b1;
          end
        SER_STOP:
          if (elem_end)
            state <= SER_IDLE;
        default:
          state <= SER_IDLE;
      endcase
    end
  end
endmodule

// ==== design/char_receive.sv ====
// Deserialises one character at the programmed format.
// Assumes the line input is already synchronised to ref_clk.
`timescale 1ns/1ps
`include "uart_line_map.svh"
module char_receive
  import uart_line_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_line,
  input wire logic [1:0] data_length_select,
  input wire logic parity_enable,
  input wire logic even_parity_select,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [7:0] data,
  output logic parity_error,
  output logic frame_error,
  output logic busy
);
  ser_state_e state;
  logic [15:0] tcnt;
  logic ht;
  logic [2:0] bidx;
  wire [15:0] lim = (divisor == 16'h0) ? 16'h0 : divisor - 16'h1;
  wire tick = (tcnt >= lim);
  wire sample = tick && ht;
  wire [2:0] last_bit = {1'b0, data_length_select} + 3'h4;
  wire expect_par = even_parity_select ? ^data : ~^data;
  assign busy = (state != SER_IDLE);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= SER_IDLE;
      tcnt <= 16'h0;
      ht <= 1'b0;
      bidx <= 3'h0;
      data <= 8'h0;
      done <= 1'b0;
      parity_error <= 1'b0;
      frame_error <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      tcnt <= (tick || state == SER_IDLE) ? 16'h0 : tcnt + 16'h1;
      if (tick)
        ht <= !ht;
      case (state)
        SER_IDLE:
          if (!rx_line)
          begin
            state <= SER_START;
            ht <= 1'b0;
          end
        SER_START:
          // Mid start bit; a high line here was a glitch.
          if (tick)
          begin
            state <= rx_line ? SER_IDLE : SER_DATA;
            ht <= 1'b0;
            bidx <= 3'h0;
            data <= 8'h0;
            parity_error <= 1'b0;
          end
        SER_DATA:
          if (sample)
          begin
            data[bidx] <= rx_line;
            bidx <= bidx + 3'h1;
            if (bidx == last_bit)
              state <= parity_enable ? SER_PARITY : SER_STOP;
          end
        SER_PARITY:
          if (sample)
          begin
            parity_error <= (rx_line != expect_par);
            state <= SER_STOP;
          end
        SER_STOP:
          // Only the first stop bit is looked at, so idle comes early.
          if (sample)
          begin
            frame_error <= !rx_line;
            done <= 1'b1;
            state <= SER_IDLE;
          end
        default:
          state <= SER_IDLE;
      endcase
    end
  end
endmodule

// ==== bench/uart_line_control_asserts.sv ====
// Checker for the line control block: register reads and line levels.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`include "uart_line_map.svh"
module uart_line_control_asserts
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic serial_in,
  input wire logic ir_in,
  input wire logic serial_out,
  input wire logic ir_out
);
  // Pulse check covers divisors up to this many cycles per half bit.
  localparam int IR_WAIT = 1000;
  logic brk;
  logic lb;
  logic ir;
  logic ir_last;
  logic [10:0] ir_still;
  wire fmt_at = addr == `ADDR_LINE_FORMAT;
  wire mc_wr = wr && addr == `ADDR_MODEM_CONTROL;
  wire mapped = addr inside {`ADDR_DATA_OR_DIV_LOW, `ADDR_DIV_HIGH_SHARED,
    `ADDR_LINE_FORMAT, `ADDR_MODEM_CONTROL, `ADDR_UNIT_STATUS};
  // Break stays writable while busy, so a write mirror is exact here.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      brk <= 1'b0;
      lb <= 1'b0;
      ir <= 1'b0;
      ir_last <= 1'b0;
      ir_still <= 11'h0;
    end
    else
    begin
      // Counts cycles of an infrared break in which the output stood.
      ir_last <= ir_out;
      if (!(brk && ir && !lb) || ir_out != ir_last)
        ir_still <= 11'h0;
      else if (ir_still != 11'h7ff)
        ir_still <= ir_still + 11'h1;
      if (wr && fmt_at)
        brk <= wdata[6];
      if (mc_wr)
        lb <= wdata[4];
      if (mc_wr)
        ir <= wdata[6];
    end
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_fmt_reserved: assert property (
    $past(rd) && $past(fmt_at) |-> rdata[31:8] == 24'h0 && !rdata[5])
    else $error("reserved format bits not zero");
  chk_break_readback: assert property (
    $past(rd) && $past(fmt_at) |-> rdata[6] == brk)
    else $error("break bit readback wrong");
  chk_rd_quiet: assert property (
    !$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_unmapped_rd: assert property (
    $past(rd) && !$past(mapped) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_break_low: assert property (
    (brk && !lb) [*3] |-> !serial_out)
    else $error("break did not hold line low");
  chk_loop_high: assert property (
    (lb && !ir) [*3] |-> serial_out)
    else $error("loopback did not hold line high");
  chk_loop_ir_low: assert property (
    lb [*3] |-> !ir_out)
    else $error("loopback infrared output not low");
  chk_ir_pulse: assert property (
    ir_still < IR_WAIT)
    else $error("infrared break not pulsing");
  cover property ((brk && !lb) [*3]);
  cover property ((brk && ir && !lb) [*3]);
  cover property ($past(rd) && $past(fmt_at));
endmodule

// ==== bench/remote_serial.sv ====
// Remote serial device at the far end of the line, behavioural.
// The bench calls its tasks; the line it drives idles high.
`timescale 1ns/1ps
module remote_serial
#(
  parameter int DIV = 16
)
(
  input wire logic ref_clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  task automatic put_bit(input logic b);
    line_out <= b;
    repeat (2 * DIV) @(posedge ref_clk);
  endtask
  // Only one stop bit is sent, whatever the block is set to expect.
  task automatic send(input logic [7:0] d, input int nb, input logic pen,
    input logic eps, input logic bad);
    @(posedge ref_clk);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++)
      put_bit(d[i]);
    if (pen)
      put_bit(^(d & (8'hff >> (8 - nb))) ^ !eps ^ bad);
    put_bit(1'b1);
  endtask
  task automatic recv(input int nb, input logic pen, output logic [7:0] d,
    output logic p, output logic ok);
    ok = 1'b0;
    d = 8'h0;
    p = 1'b0;
    for (int i = 0; i < 8000 && !ok; i++)
    begin
      @(posedge ref_clk);
      ok = !line_in;
    end
    repeat (DIV) @(posedge ref_clk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (2 * DIV) @(posedge ref_clk);
      d[i] = line_in;
    end
    if (pen)
    begin
      repeat (2 * DIV) @(posedge ref_clk);
      p = line_in;
    end
  endtask
endmodule

// ==== bench/uart_line_control_tb_top.sv ====
// Bench for the line control block: register port plus a remote device.
// The remote model drives the serial input; infrared input stays idle.
`timescale 1ns/1ps
`include "uart_line_map.svh"
module uart_line_control_tb_top;
  localparam int DIV = 16;
  localparam logic [31:0] A_DAT = `ADDR_DATA_OR_DIV_LOW;
  localparam logic [31:0] A_HI = `ADDR_DIV_HIGH_SHARED;
  localparam logic [31:0] A_FMT = `ADDR_LINE_FORMAT;
  localparam logic [31:0] A_MC = `ADDR_MODEM_CONTROL;
  localparam logic [31:0] A_ST = `ADDR_UNIT_STATUS;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic serial_in;
  logic serial_out;
  logic ir_out;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int nb;
  int st;
  int n;
  logic [31:0] v;
  logic [7:0] f;
  logic [7:0] m;
  logic [7:0] d;
  logic p;
  logic ok;
  logic [7:0] fmts [5] = '{8'h00, 8'h04, 8'h0d, 8'h1a, 8'h1f};
  always #20 ref_clk = ~ref_clk;
  uart_line_control DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_in(serial_in),
    .ir_in(1'b0), .serial_out(serial_out), .ir_out(ir_out));
  remote_serial #(.DIV(DIV)) far_end (.ref_clk(ref_clk),
    .line_in(serial_out), .line_out(serial_in));
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] dv);
    @(posedge ref_clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic final_report;
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Status polling costs two cycles a read, so stop timing is coarse.
  task automatic wait_idle();
    n = 0;
    v = 32'h1;
    while (v[0] && n < 4000)
    begin
      rd_reg(A_ST, v);
      n += 2;
    end
  endtask
  task automatic decode(input logic [7:0] fv);
    nb = int'(fv[1:0]) + 5;
    m = 8'hff >> (8 - nb);
    st = fv[2] ? (nb == 5 ? 3 * DIV : 4 * DIV) : 2 * DIV;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      final_report;
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(A_FMT, v);
    chk("format reset", 32'h0, v);
    wr_reg(A_FMT, 32'hffff_ffff);
    rd_reg(A_FMT, v);
    chk("format mask", 32'hdf, v);
    wr_reg(A_DAT, 32'(DIV));
    wr_reg(A_HI, 32'h1);
    rd_reg(A_HI, v);
    chk("divisor high", 32'h1, v);
    wr_reg(A_HI, 32'h0);
    rd_reg(A_DAT, v);
    chk("divisor low", 32'(DIV), v);
    wr_reg(A_FMT, 32'h0);
    rd_reg(A_HI, v);
    chk("divisor hidden", 32'h0, v);
    rd_reg(32'h5000_1108, v);
    chk("unmapped", 32'h0, v);
    foreach (fmts[i])
    begin
      f = fmts[i];
      decode(f);
      wr_reg(A_FMT, {24'h0, f});
      wr_reg(A_DAT, 32'ha5);
      fork
        far_end.recv(nb, f[3], d, p, ok);
        begin
          wr_reg(A_FMT, {24'h0, f ^ 8'h9f});
          rd_reg(A_FMT, v);
          chk("format while busy", {24'h0, f}, v);
        end
      join
      wait_idle();
      chk("tx start", 32'h1, {31'h0, ok});
      chk("tx data", {24'h0, 8'ha5 & m}, {24'h0, d});
      chk("tx parity", {31'h0, f[3] & (^(8'ha5 & m) ^ !f[4])},
        {31'h0, f[3] & p});
      chk("tx stop", 32'h1,
        {31'h0, n >= DIV + st - 2 && n <= DIV + st + 8});
    end
    for (int k = 0; k < 3; k++)
    begin
      f = k == 2 ? 8'h08 : 8'h1f;
      decode(f);
      wr_reg(A_FMT, {24'h0, f});
      far_end.send(8'h3c + 8'(k), nb, f[3], f[4], k == 1);
      rd_reg(A_ST, v);
      chk("rx status", {28'h0, 1'b0, k == 1, 2'b10}, v & 32'he);
      rd_reg(A_DAT, v);
      chk("rx data", {24'h0, (8'h3c + 8'(k)) & m}, v);
    end
    wr_reg(A_MC, 32'h10);
    wr_reg(A_FMT, 32'h3);
    wr_reg(A_DAT, 32'h96);
    wait_idle();
    rd_reg(A_DAT, v);
    chk("loopback data", 32'h96, v);
    wr_reg(A_FMT, 32'h43);
    rd_reg(A_FMT, v);
    chk("loop break", 32'h1, {31'h0, serial_out & !ir_out});
    repeat (320) @(posedge ref_clk);
    rd_reg(A_ST, v);
    chk("loop break rx", 32'ha, v & 32'he);
    wr_reg(A_MC, 32'h0);
    rd_reg(A_FMT, v);
    chk("break line", 32'h0, {31'h0, serial_out});
    wr_reg(A_MC, 32'h40);
    repeat (4) @(posedge ref_clk);
    #1 p = ir_out;
    repeat (DIV) @(posedge ref_clk);
    #1 chk("ir pulse", {31'h0, !p}, {31'h0, ir_out});
    wr_reg(A_MC, 32'h0);
    wr_reg(A_FMT, 32'h3);
    rd_reg(A_FMT, v);
    chk("break cleared", 32'h1, {31'h0, serial_out});
    final_report;
  end
endmodule
bind uart_line_control uart_line_control_asserts chk_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .serial_in(serial_in), .ir_in(ir_in),
  .serial_out(serial_out), .ir_out(ir_out));
